//--- shbi_pkg.sv
// Shared constants and types for the strobe host bus port.
// Assumes both ends import it whole.
package shbi_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Bus shape
    localparam int unsigned ADDR_W    = 16;
    localparam int unsigned DATA_W    = 16;
    localparam int unsigned BYTE_W    = 8;
    localparam int unsigned LANES     = 2;
    localparam int unsigned STRAP_W   = 3;

    ////////////////////////////////////////////////////////////////////////////
    // Address map
    localparam logic [15:0] MEM_LAST  = 16'h9fff;
    localparam logic [15:0] REG_FIRST = 16'hffe0;
    localparam int unsigned MEM_WORDS = 20480;
    localparam int unsigned REG_WORDS = 16;
    localparam int unsigned REG_IDX_W = 4;
    localparam int unsigned WORD_W    = 15;

    ////////////////////////////////////////////////////////////////////////////
    // Straps and idle values
    localparam logic [2:0]  MODE_BYTE_EN = 3'h7;
    localparam logic [15:0] BUS_PULL     = 16'hffff;
    localparam logic [15:0] DATA_ZERO    = 16'h0000;
    localparam int unsigned DIV_W        = 8;
    localparam logic [1:0]  STRAP_SETTLE = 2'h2;

    ////////////////////////////////////////////////////////////////////////////
    // State encodings, Gray along the cycle
    typedef enum logic [1:0] {
        DEV_IDLE   = 2'h0,
        DEV_ARB    = 2'h1,
        DEV_ACCESS = 2'h3,
        DEV_DONE   = 2'h2
    } shbi_dev_state_t;

    typedef enum logic [1:0] {
        HST_IDLE    = 2'h0,
        HST_SETUP   = 2'h1,
        HST_STROBE  = 2'h3,
        HST_RELEASE = 2'h2
    } shbi_hst_state_t;

endpackage

//--- shbi_bus_if.sv
// Board-level wiring between host end and device end.
// Assumes the testbench instantiates it and connects both ends.
interface shbi_bus_if;
    import shbi_pkg::*;

    logic                host_bus_clock;
    logic                chip_sel_n;
    logic                read_strobe_n;
    logic                write_strobe_n;
    logic                high_byte_enable_n;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   host_data;
    logic                host_data_oe;
    logic [DATA_W-1:0]   dev_data;
    logic                dev_data_oe;
    logic [DATA_W-1:0]   data;
    logic                hold_off_n;
    logic [STRAP_W-1:0]  bus_mode_straps;
    logic                bus_status_strap;
    logic                rd_wr_dir;
    logic                endian_strap;

    // Shared data wire, pulled high when nobody drives
    assign data = dev_data_oe ? dev_data : (host_data_oe ? host_data : BUS_PULL);

    modport dev (
        input  host_bus_clock, chip_sel_n, read_strobe_n, write_strobe_n, high_byte_enable_n,
        input  addr, data, bus_mode_straps, bus_status_strap, rd_wr_dir, endian_strap,
        output dev_data, dev_data_oe, hold_off_n
    );

    modport host (
        input  data, hold_off_n,
        output host_bus_clock, chip_sel_n, read_strobe_n, write_strobe_n, high_byte_enable_n,
        output addr, host_data, host_data_oe, bus_mode_straps, bus_status_strap, rd_wr_dir,
        output endian_strap
    );

endinterface

//--- shbi_sync.sv
// Two-flop synchroniser for a vector of quasi-static levels.
// Assumes bits that must agree are held stable while they matter.
module shbi_sync #(
    parameter int unsigned WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // Levels
    input  wire logic [WIDTH-1:0] d_i,
    input  wire logic [WIDTH-1:0] rst_val_i,
    output logic      [WIDTH-1:0] q_o
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } shbi_sync_t;

    shbi_sync_t s_q;
    shbi_sync_t s_d;

    always_comb
    begin
        s_d.meta   = d_i;
        s_d.stable = s_q.meta;
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            s_q <= '1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Idle value is all ones; rst_val_i is kept for width documentation only
    assign q_o = s_q.stable & (rst_val_i | ~rst_val_i);

endmodule

//--- shbi_dev.sv
// Device end of the strobe host bus port: byte-enable mode, 16-bit,
// display memory and control registers behind a hold-off handshake.
// Assumes the host keeps address, data and enables stable while a strobe is low.
//
// Operation
// - Sixteen address inputs, sixteen-bit two-way data
// - Straps sampled at reset fix bus mode
// - Straps 111 with status high: byte-enable mode
// - Host cycles run on the host bus clock
// - Endian strap at reset picks byte order
// - Host decodes chip select from high address; shbi_host asserts it for every request, whatever the address
// - High byte enable qualifies upper data byte
// - Low write strobe marks a write access
// - Host drives read strobe low to read
// - Hold-off shows read data valid, write accepted
// - Hold-off stays asserted through refresh arbitration
// - Hold-off is active low
// - Board ties status and direction pins high
// - Host keeps a stable demultiplexed address
// - Display memory at 0000h through 9FFFh
// - Control registers at FFE0h through FFFFh
module shbi_dev
    import shbi_pkg::*;
(
    // Reset
    input  wire logic  rst_i,
    // Host bus
    shbi_bus_if.dev    bus,
    // Display refresh arbitration
    input  wire logic  refresh_req_i,
    output logic       refresh_gnt_o,
    // Configuration status
    output logic       mode_ok_o,
    output logic       big_endian_o
);

    localparam int unsigned IN_W = 4 + ADDR_W + DATA_W + STRAP_W + 2;

    typedef struct packed {
        shbi_dev_state_t      state;
        logic                 cfg_done;
        logic [1:0]           cfg_wait;
        logic                 mode_ok;
        logic                 big_endian;
        logic [ADDR_W-1:0]    addr;
        logic                 is_write;
        logic [LANES-1:0]     lanes;
        logic [DATA_W-1:0]    rdata;
    } shbi_dev_regs_t;

    shbi_dev_regs_t r_q;
    shbi_dev_regs_t r_d;

    logic [DATA_W-1:0]   mem [MEM_WORDS];
    logic [DATA_W-1:0]   regs [REG_WORDS];
    logic                mem_we;
    logic                reg_we;
    logic [LANES-1:0]    we_lanes;
    logic [DATA_W-1:0]   wdata;

    logic [IN_W-1:0]     in_raw;
    logic [IN_W-1:0]     in_s;
    logic                cs_n_s;
    logic                rd_n_s;
    logic                wr_n_s;
    logic                hbe_n_s;
    logic [ADDR_W-1:0]   addr_s;
    logic [DATA_W-1:0]   data_s;
    logic [STRAP_W-1:0]  mode_s;
    logic                status_s;
    logic                endian_s;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [DATA_W-1:0] shbi_swap(input logic [DATA_W-1:0] w, input logic en);
        shbi_swap = en ? {w[BYTE_W-1:0], w[DATA_W-1:BYTE_W]} : w;
    endfunction

    function automatic logic shbi_is_mem(input logic [ADDR_W-1:0] a);
        shbi_is_mem = (a <= MEM_LAST);
    endfunction

    function automatic logic shbi_is_reg(input logic [ADDR_W-1:0] a);
        shbi_is_reg = (a >= REG_FIRST);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers into the host bus clock domain

    assign in_raw = {bus.chip_sel_n, bus.read_strobe_n, bus.write_strobe_n, bus.high_byte_enable_n,
                     bus.addr, bus.data, bus.bus_mode_straps, bus.bus_status_strap,
                     bus.endian_strap};

    shbi_sync #(
        .WIDTH (IN_W)
    ) u_sync (
        .clk_i     (bus.host_bus_clock),
        .rst_i     (rst_i),
        .d_i       (in_raw),
        .rst_val_i ({IN_W{1'b1}}),
        .q_o       (in_s)
    );

    assign {cs_n_s, rd_n_s, wr_n_s, hbe_n_s, addr_s, data_s, mode_s, status_s, endian_s} = in_s;

    ////////////////////////////////////////////////////////////////////////////
    // Cycle sequencer

    always_comb
    begin
        r_d      = r_q;
        mem_we   = 1'b0;
        reg_we   = 1'b0;
        we_lanes = '0;
        wdata    = shbi_swap(data_s, r_q.big_endian);

        // Straps are taken once, after they have crossed both synchroniser flops
        if (!r_q.cfg_done)
        begin
            r_d.cfg_wait = r_q.cfg_wait + 2'h1;
            if (r_q.cfg_wait == STRAP_SETTLE)
            begin
                r_d.cfg_done   = 1'b1;
                r_d.mode_ok    = (mode_s == MODE_BYTE_EN) && status_s;
                r_d.big_endian = endian_s;
            end
        end

        case (r_q.state)
            DEV_IDLE:
            begin
                if (r_q.cfg_done && r_q.mode_ok && !cs_n_s && (!rd_n_s || !wr_n_s))
                begin
                    r_d.state    = DEV_ARB;
                    r_d.addr     = addr_s;
                    r_d.is_write = !wr_n_s;
                    // Upper lane from the high byte enable, lower lane from even address; big endian swaps the two
                    r_d.lanes    = {!hbe_n_s, !addr_s[0]};
                    if (r_q.big_endian)
                    begin
                        r_d.lanes = {!addr_s[0], !hbe_n_s};
                    end
                end
            end
            DEV_ARB:
            begin
                // Refresh owns memory and registers while it asks, except while a cycle is in DEV_ACCESS
                if (!refresh_req_i)
                begin
                    r_d.state = DEV_ACCESS;
                end
            end
            DEV_ACCESS:
            begin
                r_d.state = DEV_DONE;
                r_d.rdata = DATA_ZERO;
                if (shbi_is_mem(r_q.addr))
                begin
                    mem_we    = r_q.is_write;
                    r_d.rdata = shbi_swap(mem[r_q.addr[ADDR_W-1:1]], r_q.big_endian);
                end
                else if (shbi_is_reg(r_q.addr))
                begin
                    reg_we    = r_q.is_write;
                    r_d.rdata = shbi_swap(regs[r_q.addr[REG_IDX_W:1]], r_q.big_endian);
                end
                we_lanes = r_q.lanes;
            end
            DEV_DONE:
            begin
                // Hold the answer until the host lets go of its strobe
                if (cs_n_s || (rd_n_s && wr_n_s))
                begin
                    r_d.state = DEV_IDLE;
                end
            end
            default:
            begin
                r_d.state = DEV_IDLE;
            end
        endcase
    end

    always_ff @(posedge bus.host_bus_clock or posedge rst_i)
    begin
        if (rst_i)
        begin
            r_q <= '{state: DEV_IDLE, cfg_done: 1'b0, cfg_wait: 2'h0, mode_ok: 1'b0, big_endian: 1'b0,
                     addr: '0, is_write: 1'b0, lanes: '0, rdata: DATA_ZERO};
        end
        else
        begin
            r_q <= r_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Storage, written lane by lane

    always_ff @(posedge bus.host_bus_clock)
    begin
        for (int i = 0; i < LANES; i++)
        begin
            if (mem_we && we_lanes[i])
            begin
                mem[r_q.addr[ADDR_W-1:1]][i*BYTE_W +: BYTE_W] <= wdata[i*BYTE_W +: BYTE_W];
            end
            if (reg_we && we_lanes[i])
            begin
                regs[r_q.addr[REG_IDX_W:1]][i*BYTE_W +: BYTE_W] <= wdata[i*BYTE_W +: BYTE_W];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    // Released high only once read data is on the bus or write data is stored
    assign bus.hold_off_n   = (r_q.state == DEV_DONE);
    assign bus.dev_data     = r_q.rdata;
    assign bus.dev_data_oe  = (r_q.state == DEV_DONE) && !r_q.is_write;
    assign refresh_gnt_o    = refresh_req_i && (r_q.state != DEV_ACCESS);
    assign mode_ok_o        = r_q.mode_ok;
    assign big_endian_o     = r_q.big_endian;

endmodule

//--- shbi_host.sv
// Host end: CPU with decode glue, making the bus clock, strobes and straps.
// Assumes the user holds a request stable while valid and not ready.
module shbi_host
    import shbi_pkg::*;
#(
    parameter int unsigned BUS_DIV    = 1,
    parameter logic        BIG_ENDIAN = 1'b0
) (
    // Clock and reset
    input  wire logic               ref_clk_i,
    input  wire logic               rst_i,
    // Request
    input  wire logic               req_valid_i,
    output logic                    req_ready_o,
    input  wire logic               req_write_i,
    input  wire logic               req_hi_en_i,
    input  wire logic [ADDR_W-1:0]  req_addr_i,
    input  wire logic [DATA_W-1:0]  req_wdata_i,
    // Answer
    output logic                    resp_valid_o,
    output logic [DATA_W-1:0]       resp_rdata_o,
    // Host bus
    shbi_bus_if.host                bus
);

    typedef struct packed {
        shbi_hst_state_t    state;
        logic [DIV_W-1:0]   div_cnt;
        logic               bclk;
        logic               cs_n;
        logic               rd_n;
        logic               wr_n;
        logic               hbe_n;
        logic               oe;
        logic               is_write;
        logic               hold_seen;
        logic [ADDR_W-1:0]  addr;
        logic [DATA_W-1:0]  wdata;
        logic [DATA_W-1:0]  rdata;
        logic               resp;
    } shbi_host_regs_t;

    shbi_host_regs_t r_q;
    shbi_host_regs_t r_d;

    logic [DATA_W:0] in_s;
    logic            hold_n_s;
    logic [DATA_W-1:0] data_s;

    shbi_sync #(
        .WIDTH (DATA_W + 1)
    ) u_sync (
        .clk_i     (ref_clk_i),
        .rst_i     (rst_i),
        .d_i       ({bus.hold_off_n, bus.data}),
        .rst_val_i ({(DATA_W + 1){1'b1}}),
        .q_o       (in_s)
    );

    assign {hold_n_s, data_s} = in_s;

    always_comb
    begin
        r_d      = r_q;
        r_d.resp = 1'b0;

        // Bus clock: ref clock divided by 2*BUS_DIV
        r_d.div_cnt = r_q.div_cnt + DIV_W'(1);
        if (r_q.div_cnt == DIV_W'(BUS_DIV - 1))
        begin
            r_d.div_cnt = '0;
            r_d.bclk    = !r_q.bclk;
        end

        case (r_q.state)
            HST_IDLE:
            begin
                if (req_valid_i && !hold_n_s)
                begin
                    r_d.state    = HST_SETUP;
                    r_d.addr     = req_addr_i;
                    r_d.wdata    = req_wdata_i;
                    r_d.is_write = req_write_i;
                    r_d.cs_n     = 1'b0;
                    r_d.hbe_n    = !req_hi_en_i;
                    r_d.oe       = req_write_i;
                end
            end
            HST_SETUP:
            begin
                r_d.state = HST_STROBE;
                r_d.wr_n  = !r_q.is_write;
                r_d.rd_n  = r_q.is_write;
            end
            HST_STROBE:
            begin
                // Two agreeing samples of a released hold-off before data is taken
                if (hold_n_s)
                begin
                    r_d.hold_seen = 1'b1;
                    if (r_q.hold_seen)
                    begin
                        r_d.state     = HST_RELEASE;
                        r_d.hold_seen = 1'b0;
                        r_d.rdata     = r_q.is_write ? r_q.rdata : data_s;
                        r_d.resp      = 1'b1;
                        r_d.cs_n      = 1'b1;
                        r_d.rd_n      = 1'b1;
                        r_d.wr_n      = 1'b1;
                        r_d.hbe_n     = 1'b1;
                        r_d.oe        = 1'b0;
                    end
                end
            end
            HST_RELEASE:
            begin
                if (!hold_n_s)
                begin
                    r_d.state = HST_IDLE;
                end
            end
            default:
            begin
                r_d.state = HST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            r_q <= '{state: HST_IDLE, div_cnt: '0, bclk: 1'b0, cs_n: 1'b1, rd_n: 1'b1,
                     wr_n: 1'b1, hbe_n: 1'b1, oe: 1'b0, is_write: 1'b0, hold_seen: 1'b0,
                     addr: '0, wdata: DATA_ZERO, rdata: DATA_ZERO, resp: 1'b0};
        end
        else
        begin
            r_q <= r_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs and board ties

    assign req_ready_o             = (r_q.state == HST_IDLE) && !hold_n_s;
    assign resp_valid_o            = r_q.resp;
    assign resp_rdata_o            = r_q.rdata;
    assign bus.host_bus_clock      = r_q.bclk;
    assign bus.chip_sel_n          = r_q.cs_n;
    assign bus.read_strobe_n       = r_q.rd_n;
    assign bus.write_strobe_n      = r_q.wr_n;
    assign bus.high_byte_enable_n  = r_q.hbe_n;
    assign bus.addr                = r_q.addr;
    assign bus.host_data           = r_q.wdata;
    assign bus.host_data_oe        = r_q.oe;
    assign bus.bus_mode_straps     = MODE_BYTE_EN;
    assign bus.bus_status_strap    = 1'b1;
    assign bus.rd_wr_dir           = 1'b1;
    assign bus.endian_strap        = BIG_ENDIAN;

endmodule

//--- shbi_bus_chk.sv
// Checker for the link between host end and device end.
// Assumes the bench wires it to the interface signals by name.
module shbi_bus_chk
    import shbi_pkg::*;
(
    // Clock and reset
    input  wire logic               host_bus_clock,
    input  wire logic               rst_i,
    // Link
    input  wire logic               chip_sel_n,
    input  wire logic               read_strobe_n,
    input  wire logic               write_strobe_n,
    input  wire logic               high_byte_enable_n,
    input  wire logic [ADDR_W-1:0]  addr,
    input  wire logic               host_data_oe,
    input  wire logic               dev_data_oe,
    input  wire logic               hold_off_n,
    input  wire logic [STRAP_W-1:0] bus_mode_straps,
    input  wire logic               bus_status_strap,
    input  wire logic               rd_wr_dir
);
    timeunit 1ns;
    timeprecision 100ps;

    default clocking @(posedge host_bus_clock); endclocking
    default disable iff (rst_i);

    logic strb;
    assign strb = !read_strobe_n || !write_strobe_n;

    ////////////////////////////////////////////////////////////////////////
    a_strobe_under_sel: assert property (strb |-> !chip_sel_n)
        else $error("strobe without select");
    a_one_strobe: assert property (!(!read_strobe_n && !write_strobe_n))
        else $error("both strobes low");
    a_holdoff_cause: assert property ($rose(hold_off_n) |-> !chip_sel_n && strb)
        else $error("hold-off rose without a cycle");
    a_holdoff_stands: assert property (hold_off_n && !chip_sel_n && strb |=> hold_off_n)
        else $error("hold-off dropped early");
    a_idle_holdoff: assert property (chip_sel_n [*5] |-> !hold_off_n)
        else $error("hold-off high while idle");
    a_read_drives: assert property (hold_off_n && !read_strobe_n |-> dev_data_oe)
        else $error("read answered without data");
    a_no_clash: assert property (!(dev_data_oe && host_data_oe))
        else $error("both ends drive data");
    a_write_quiet: assert property (!write_strobe_n |-> !dev_data_oe)
        else $error("device drives during write");
    a_addr_steady: assert property (!chip_sel_n && !$past(chip_sel_n) |->
        $stable(addr) && $stable(high_byte_enable_n))
        else $error("address moved in a cycle");
    a_board_ties: assert property (bus_mode_straps == MODE_BYTE_EN && bus_status_strap && rd_wr_dir)
        else $error("straps not tied high");

    c_read: cover property ($rose(hold_off_n) && !read_strobe_n);
    c_write: cover property ($rose(hold_off_n) && !write_strobe_n);
    c_long: cover property (!chip_sel_n && !hold_off_n [*8]);
endmodule

//--- tb.sv
// Bench: host end against device end, plus a bench-driven second device.
// Assumes package, interface and both ends are compiled first.
module tb
    import shbi_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic        ref_clk_i = 1'b0;
    logic        rst_i;
    logic        req_valid = 1'b0;
    logic        req_write = 1'b0;
    logic        req_hi_en = 1'b0;
    logic [15:0] req_addr = 16'h0000;
    logic [15:0] req_wdata = 16'h0000;
    logic        refresh_req = 1'b0;
    logic        req_ready;
    logic        resp_valid;
    logic [15:0] resp_rdata;
    logic        refresh_gnt;
    logic        mode_ok;
    logic        big_end;
    logic        mode_ok_b;
    logic        big_end_b;
    int          err_count = 0;
    int          total_checks = 0;
    logic [15:0] corner [6] = '{16'h0000, 16'h9ffe, 16'ha000, 16'hffde, 16'hffe0, 16'hfffe};

    shbi_bus_if bus ();
    shbi_bus_if bus_b ();

    shbi_host #(.BUS_DIV(1), .BIG_ENDIAN(1'b1)) u_shbi_host (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .req_valid_i(req_valid), .req_ready_o(req_ready),
        .req_write_i(req_write), .req_hi_en_i(req_hi_en), .req_addr_i(req_addr),
        .req_wdata_i(req_wdata), .resp_valid_o(resp_valid), .resp_rdata_o(resp_rdata), .bus(bus.host));
    shbi_dev u_shbi_dev (.rst_i(rst_i), .bus(bus.dev), .refresh_req_i(refresh_req),
        .refresh_gnt_o(refresh_gnt), .mode_ok_o(mode_ok), .big_endian_o(big_end));
    shbi_dev u_shbi_dev_b (.rst_i(rst_i), .bus(bus_b.dev), .refresh_req_i(1'b0),
        .refresh_gnt_o(), .mode_ok_o(mode_ok_b), .big_endian_o(big_end_b));
    shbi_bus_chk u_shbi_bus_chk (.host_bus_clock(bus.host_bus_clock), .rst_i(rst_i),
        .chip_sel_n(bus.chip_sel_n), .read_strobe_n(bus.read_strobe_n),
        .write_strobe_n(bus.write_strobe_n), .high_byte_enable_n(bus.high_byte_enable_n),
        .addr(bus.addr), .host_data_oe(bus.host_data_oe), .dev_data_oe(bus.dev_data_oe),
        .hold_off_n(bus.hold_off_n), .bus_mode_straps(bus.bus_mode_straps),
        .bus_status_strap(bus.bus_status_strap), .rd_wr_dir(bus.rd_wr_dir));

    always #12.5 ref_clk_i = ~ref_clk_i;
    always #7.5 bus_b.host_bus_clock = ~bus_b.host_bus_clock;

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_sim;
        if (err_count == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Unmapped words read as zero, byte lanes merge into the old word
    function automatic logic [15:0] expect_word(input logic [15:0] a, input logic [15:0] old,
                                              input logic [15:0] d, input logic lo, input logic hi);
        if (a > MEM_LAST && a < REG_FIRST)
            return 16'h0000;
        return {hi ? d[15:8] : old[15:8], lo ? d[7:0] : old[7:0]};
    endfunction

    task automatic wait_sig(input bit resp);
        int n;
        n = 0;
        do
        begin
            @(negedge ref_clk_i);
            n++;
        end
        while ((resp ? resp_valid : req_ready) !== 1'b1 && n < 400);
    endtask

    task automatic access(input logic wr, input logic hi, input logic [15:0] a,
                          input logic [15:0] d, input bit stall, output logic [15:0] rd);
        @(posedge ref_clk_i);
        req_valid <= 1'b1;
        req_write <= wr;
        req_hi_en <= hi;
        req_addr <= a;
        req_wdata <= d;
        wait_sig(1'b0);
        @(posedge ref_clk_i);
        req_valid <= 1'b0;
        if (stall)
        begin
            repeat (60) @(negedge ref_clk_i);
            check("stalled hold_off_n", {15'h0, bus.hold_off_n}, 16'h0000);
            check("refresh grant", {15'h0, refresh_gnt}, 16'h0001);
            check("stalled resp_valid", {15'h0, resp_valid}, 16'h0000);
            @(posedge ref_clk_i);
            refresh_req <= 1'b0;
        end
        wait_sig(1'b1);
        check("resp_valid", {15'h0, resp_valid}, 16'h0001);
        rd = resp_rdata;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        logic [15:0] a;
        logic [15:0] d;
        logic [15:0] d2;
        logic [15:0] r;
        logic        m;
        rst_i <= 1'b1;
        bus_b.host_bus_clock = 1'b0;
        bus_b.chip_sel_n = 1'b1;
        bus_b.read_strobe_n = 1'b1;
        bus_b.write_strobe_n = 1'b1;
        bus_b.high_byte_enable_n = 1'b1;
        bus_b.addr = 16'ha000;
        bus_b.host_data = 16'h0000;
        bus_b.host_data_oe = 1'b0;
        bus_b.bus_mode_straps = MODE_BYTE_EN;
        bus_b.bus_status_strap = 1'b1;
        bus_b.rd_wr_dir = 1'b1;
        bus_b.endian_strap = 1'b0;
        void'($urandom(39));
        repeat (2) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        repeat (10) @(posedge ref_clk_i);
        check("mode_ok", {15'h0, mode_ok}, 16'h0001);
        check("big_endian", {15'h0, big_end}, 16'h0001);
        for (int i = 0; i < 48; i++)
        begin
            case ($urandom % 4)
                0: a = 16'(($urandom % MEM_WORDS) * 2);
                1: a = corner[$urandom % 6];
                2: a = REG_FIRST + 16'(($urandom % REG_WORDS) * 2);
                default: a = 16'ha000 + 16'(($urandom % 12272) * 2);
            endcase
            d = 16'($urandom);
            d2 = 16'($urandom);
            m = 1'($urandom);
            access(1'b1, 1'b1, a, d, 1'b0, r);
            access(1'b0, 1'b1, a, 16'h0000, 1'b0, r);
            check("full word", r, expect_word(a, d, d, 1'b1, 1'b1));
            access(1'b1, m, a | {15'h0, m}, d2, 1'b0, r);
            access(1'b0, 1'b1, a, 16'h0000, 1'b0, r);
            check("byte lane", r, expect_word(a, d, d2, !m, m));
        end
        @(posedge ref_clk_i);
        refresh_req <= 1'b1;
        access(1'b1, 1'b1, 16'hffe2, 16'h5aa5, 1'b1, r);
        access(1'b0, 1'b1, 16'hffe2, 16'h0000, 1'b0, r);
        check("after refresh", r, 16'h5aa5);
        // Second device: strobe without select, then a real read
        check("mode_ok second", {15'h0, mode_ok_b}, 16'h0001);
        check("big_endian second", {15'h0, big_end_b}, 16'h0000);
        @(posedge bus_b.host_bus_clock);
        bus_b.read_strobe_n <= 1'b0;
        repeat (30) @(negedge bus_b.host_bus_clock);
        check("ignored hold_off_n", {15'h0, bus_b.hold_off_n}, 16'h0000);
        check("ignored drive", {15'h0, bus_b.dev_data_oe}, 16'h0000);
        @(posedge bus_b.host_bus_clock);
        bus_b.chip_sel_n <= 1'b0;
        for (int n = 0; n < 20 && bus_b.hold_off_n !== 1'b1; n++)
            @(negedge bus_b.host_bus_clock);
        check("link hold_off_n", {15'h0, bus_b.hold_off_n}, 16'h0001);
        check("unmapped data", bus_b.data, 16'h0000);
        @(posedge bus_b.host_bus_clock);
        bus_b.chip_sel_n <= 1'b1;
        bus_b.read_strobe_n <= 1'b1;
        repeat (6) @(negedge bus_b.host_bus_clock);
        check("released hold_off_n", {15'h0, bus_b.hold_off_n}, 16'h0000);
        end_sim;
    end

    initial
    begin
        repeat (30000) @(posedge ref_clk_i);
        err_count++;
        end_sim;
    end
endmodule
